// >>> inc/ahp_pkg.sv
// Package for the asynchronous host port: widths, timing and reset values.
// Assumes a single 125 MHz clock shared by both ends.
package ahp_pkg;
  // ==========================================================================
  // Widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int CHAN_W = 32;
  localparam int BUFC_W = 4;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int GAP_NS          = 30;
  localparam int GAP_CYCLES      = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_LAT_CYCLES  = 2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] DATA_RST  = 16'h0000;
  localparam logic [3:0]  BUFC_RST  = 4'h0;
  localparam logic [1:0]  SYNC_RST  = 2'h3;
endpackage

// >>> inc/ahp_if.sv
// Host port interface joining the device end and the host end.
// The interface resolves the shared data bus and pulled-up acknowledge.
`timescale 1ns/1ns
`default_nettype none
interface ahp_if;
  import ahp_pkg::*;
  logic [ADDR_W-1:0] host_address;
  logic              select_n;
  logic              data_strobe_n;
  logic              read_not_write;
  logic [DATA_W-1:0] host_data_h2d;
  logic              host_data_h2d_oe;
  logic [DATA_W-1:0] host_data_d2h;
  logic              host_data_d2h_oe;
  logic [DATA_W-1:0] host_data;
  logic              transfer_ack_n_out;
  logic              transfer_ack_n_oe;
  logic              transfer_ack_n;

  // Shared wire level worked out from the enables; pull-up on acknowledge
  always_comb begin
    if (host_data_d2h_oe) begin
      host_data = host_data_d2h;
    end else if (host_data_h2d_oe) begin
      host_data = host_data_h2d;
    end else begin
      host_data = '1;
    end
    transfer_ack_n = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1;
  end

  modport device (
    input  host_address, select_n, data_strobe_n, read_not_write, host_data,
    output host_data_d2h, host_data_d2h_oe, transfer_ack_n_out, transfer_ack_n_oe
  );
  modport host (
    output host_address, select_n, data_strobe_n, read_not_write,
    output host_data_h2d, host_data_h2d_oe,
    input  host_data, transfer_ack_n
  );
endinterface
`default_nettype wire

// >>> logic/ahp_device.sv
// Device end of the asynchronous host port with reset handling.
// Assumes host signals are synchronous to clk_in; user side is a simple
// word memory port and the reset-controlled serial/buffer control outputs.
`timescale 1ns/1ns
`default_nettype none
module ahp_device
  import ahp_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  ahp_if.device                  bus,
  input  wire logic              local_idle_level_select_in,
  input  wire logic              backplane_idle_level_select_in,
  input  wire logic [CHAN_W-1:0] local_serial_data_in,
  input  wire logic [CHAN_W-1:0] backplane_serial_data_in,
  input  wire logic [BUFC_W-1:0] local_buffer_request_in,
  input  wire logic [BUFC_W-1:0] backplane_buffer_request_in,
  input  wire logic [DW-1:0]     user_read_data_in,
  output logic                   user_write_out,
  output logic                   user_read_out,
  output logic [AW-1:0]          user_address_out,
  output logic [DW-1:0]          user_write_data_out,
  output logic                   in_reset_out,
  output logic [15:0]            access_count_out,
  output logic [CHAN_W-1:0]      local_serial_out,
  output logic [CHAN_W-1:0]      local_serial_oe_out,
  output logic [CHAN_W-1:0]      backplane_serial_out,
  output logic [CHAN_W-1:0]      backplane_serial_oe_out,
  output logic [BUFC_W-1:0]      local_buffer_enable_out,
  output logic [BUFC_W-1:0]      backplane_buffer_enable_out
);
  typedef enum logic [1:0] {AHP_IDLE, AHP_WAIT, AHP_ACK} ahp_state_t;

  // ==========================================================================
  // Reset synchroniser: async assert, clocked release
  logic [1:0] rst_sync_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_sync_reg <= SYNC_RST;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b0};
    end
  end
  logic core_rst;
  assign core_rst = rst_sync_reg[1];

  // ==========================================================================
  // Host handshake
  ahp_state_t        state_reg, state_next;
  logic [1:0]        lat_reg, lat_next;
  logic              ack_reg, ack_next;
  logic              drive_reg, drive_next;
  logic [DW-1:0]     rdata_reg, rdata_next;
  logic              wr_reg, wr_next;
  logic              rd_reg, rd_next;
  logic [AW-1:0]     addr_reg, addr_next;
  logic [DW-1:0]     wdata_reg, wdata_next;
  logic [15:0]       cnt_reg, cnt_next;
  logic              access;

  assign access = !bus.select_n && !bus.data_strobe_n;

  always_comb begin
    state_next = state_reg;
    lat_next   = lat_reg;
    ack_next   = ack_reg;
    drive_next = drive_reg;
    rdata_next = rdata_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      AHP_IDLE: begin
        if (access) begin
          addr_next  = bus.host_address;
          lat_next   = 2'(ACK_LAT_CYCLES - 1);
          state_next = AHP_WAIT;
          if (bus.read_not_write) begin
            rd_next = 1'b1;
          end else begin
            wr_next    = 1'b1;
            wdata_next = bus.host_data;
          end
        end
      end
      AHP_WAIT: begin
        if (!access) begin
          state_next = AHP_IDLE;
        end else if (lat_reg == 2'h0) begin
          if (bus.read_not_write) begin
            rdata_next = user_read_data_in;
            drive_next = 1'b1;
          end
          ack_next   = 1'b1;
          cnt_next   = cnt_reg + 16'h0001;
          state_next = AHP_ACK;
        end else begin
          lat_next = lat_reg - 2'h1;
        end
      end
      AHP_ACK: begin
        if (!access) begin
          ack_next   = 1'b0;
          drive_next = 1'b0;
          state_next = AHP_IDLE;
        end
      end
      default: state_next = AHP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= AHP_IDLE;
      lat_reg   <= 2'h0;
      ack_reg   <= 1'b0;
      drive_reg <= 1'b0;
      rdata_reg <= DATA_RST;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= DATA_RST;
      cnt_reg   <= 16'h0000;
    end else if (core_rst) begin
      state_reg <= AHP_IDLE;
      lat_reg   <= 2'h0;
      ack_reg   <= 1'b0;
      drive_reg <= 1'b0;
      rdata_reg <= DATA_RST;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= DATA_RST;
      cnt_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      lat_reg   <= lat_next;
      ack_reg   <= ack_next;
      drive_reg <= drive_next;
      rdata_reg <= rdata_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Acknowledge only ever driven low; released line floats to the pull-up
  assign bus.transfer_ack_n_out = 1'b0;
  assign bus.transfer_ack_n_oe  = ack_reg;
  assign bus.host_data_d2h      = rdata_reg;
  assign bus.host_data_d2h_oe   = drive_reg;

  assign user_write_out      = wr_reg;
  assign user_read_out       = rd_reg;
  assign user_address_out    = addr_reg;
  assign user_write_data_out = wdata_reg;
  assign access_count_out    = cnt_reg;

  // ==========================================================================
  // Serial and buffer control outputs, registered
  logic [CHAN_W-1:0] ls_reg, ls_next, lso_reg, lso_next;
  logic [CHAN_W-1:0] bs_reg, bs_next, bso_reg, bso_next;
  logic [BUFC_W-1:0] lb_reg, lb_next, bb_reg, bb_next;
  logic              inr_reg;

  always_comb begin
    if (core_rst) begin
      ls_next  = '1;
      bs_next  = '1;
      lso_next = {CHAN_W{local_idle_level_select_in}};
      bso_next = {CHAN_W{backplane_idle_level_select_in}};
      lb_next  = BUFC_RST;
      bb_next  = BUFC_RST;
    end else begin
      ls_next  = local_serial_data_in;
      bs_next  = backplane_serial_data_in;
      lso_next = '1;
      bso_next = '1;
      lb_next  = local_buffer_request_in;
      bb_next  = backplane_buffer_request_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ls_reg  <= '1;
      bs_reg  <= '1;
      lb_reg  <= BUFC_RST;
      bb_reg  <= BUFC_RST;
      inr_reg <= 1'b1;
    end else begin
      ls_reg  <= ls_next;
      bs_reg  <= bs_next;
      lb_reg  <= lb_next;
      bb_reg  <= bb_next;
      inr_reg <= core_rst;
    end
  end

  // Straps are not constants, so these enables carry no async reset value;
  // core_rst is set at once, so they follow the idle select from the first
  // edge while reset is held
  always_ff @(posedge clk_in) begin
    lso_reg <= lso_next;
    bso_reg <= bso_next;
  end

  assign local_serial_out            = ls_reg;
  assign local_serial_oe_out         = lso_reg;
  assign backplane_serial_out        = bs_reg;
  assign backplane_serial_oe_out     = bso_reg;
  assign local_buffer_enable_out     = lb_reg;
  assign backplane_buffer_enable_out = bb_reg;
  assign in_reset_out                = inr_reg;
endmodule
`default_nettype wire

// >>> logic/ahp_host.sv
// Host end of the asynchronous host port: turns a user request into a strobe cycle.
// Assumes the acknowledge line is pulled up by the interface when released.
`timescale 1ns/1ns
`default_nettype none
module ahp_host
  import ahp_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  ahp_if.host                    bus,
  input  wire logic              req_in,
  input  wire logic              req_read_in,
  input  wire logic [ADDR_W-1:0] req_address_in,
  input  wire logic [DATA_W-1:0] req_write_data_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic [DATA_W-1:0]      read_data_out
);
  typedef enum logic [1:0] {AHH_IDLE, AHH_STROBE, AHH_RELEASE, AHH_GAP} ahh_state_t;

  ahh_state_t        state_reg, state_next;
  logic              strobe_reg, strobe_next;
  logic              rnw_reg, rnw_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic              done_reg, done_next;
  logic [3:0]        gap_reg, gap_next;

  // ==========================================================================
  // Strobe sequencer
  always_comb begin
    state_next  = state_reg;
    strobe_next = strobe_reg;
    rnw_next    = rnw_reg;
    addr_next   = addr_reg;
    wd_next     = wd_reg;
    rd_next     = rd_reg;
    done_next   = 1'b0;
    gap_next    = gap_reg;
    case (state_reg)
      AHH_IDLE: begin
        if (req_in) begin
          addr_next   = req_address_in;
          wd_next     = req_write_data_in;
          rnw_next    = req_read_in;
          strobe_next = 1'b1;
          state_next  = AHH_STROBE;
        end
      end
      AHH_STROBE: begin
        if (!bus.transfer_ack_n) begin
          if (rnw_reg) begin
            rd_next = bus.host_data;
          end
          strobe_next = 1'b0;
          state_next  = AHH_RELEASE;
        end
      end
      AHH_RELEASE: begin
        // Gap counts from the acknowledge going high, not from our release
        if (bus.transfer_ack_n) begin
          gap_next   = 4'(GAP_CYCLES);
          done_next  = 1'b1;
          state_next = AHH_GAP;
        end
      end
      AHH_GAP: begin
        if (gap_reg <= 4'h1) begin
          state_next = AHH_IDLE;
        end else begin
          gap_next = gap_reg - 4'h1;
        end
      end
      default: state_next = AHH_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg  <= AHH_IDLE;
      strobe_reg <= 1'b0;
      rnw_reg    <= 1'b1;
      addr_reg   <= '0;
      wd_reg     <= DATA_RST;
      rd_reg     <= DATA_RST;
      done_reg   <= 1'b0;
      gap_reg    <= 4'h0;
    end else begin
      state_reg  <= state_next;
      strobe_reg <= strobe_next;
      rnw_reg    <= rnw_next;
      addr_reg   <= addr_next;
      wd_reg     <= wd_next;
      rd_reg     <= rd_next;
      done_reg   <= done_next;
      gap_reg    <= gap_next;
    end
  end

  assign bus.select_n         = !strobe_reg;
  assign bus.data_strobe_n    = !strobe_reg;
  assign bus.read_not_write   = rnw_reg;
  assign bus.host_address     = addr_reg;
  assign bus.host_data_h2d    = wd_reg;
  assign bus.host_data_h2d_oe = strobe_reg && !rnw_reg;
  assign busy_out             = (state_reg != AHH_IDLE);
  assign done_out             = done_reg;
  assign read_data_out        = rd_reg;
endmodule
`default_nettype wire

// >>> verif/ahp_props.sv
// Checker for the host port wires between the device end and the host end.
// Assumes the bench instantiates it beside the interface and feeds its signals.
`timescale 1ns/1ns
`default_nettype none
module ahp_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic select_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic host_data_h2d_oe,
  input wire logic host_data_d2h_oe,
  input wire logic transfer_ack_n_oe,
  input wire logic transfer_ack_n
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================================
  // Handshake
  ack_needs_access_a: assert property ($rose(transfer_ack_n_oe) |->
    $past(!select_n && !data_strobe_n) && !select_n && !data_strobe_n)
    else $error("acknowledge without select and strobe");
  ack_latency_a: assert property ($fell(data_strobe_n) && !select_n |->
    ##[2:4] transfer_ack_n_oe) else $error("acknowledge late");
  ack_holds_a: assert property (transfer_ack_n_oe && !select_n && !data_strobe_n
    |=> transfer_ack_n_oe) else $error("acknowledge dropped early");
  ack_release_a: assert property (transfer_ack_n_oe && (select_n || data_strobe_n)
    |-> ##[1:2] !transfer_ack_n_oe) else $error("acknowledge not released");
  ack_level_a: assert property (transfer_ack_n == !transfer_ack_n_oe)
    else $error("acknowledge level wrong");
  // ==========================================================================
  // Data direction
  read_drive_a: assert property ($rose(host_data_d2h_oe) |->
    read_not_write && $rose(transfer_ack_n_oe)) else $error("read drive misplaced");
  write_quiet_a: assert property (transfer_ack_n_oe && !read_not_write && !data_strobe_n
    |-> !host_data_d2h_oe) else $error("device drives on write");
  no_contention_a: assert property (!(host_data_d2h_oe && host_data_h2d_oe))
    else $error("both ends drive data");
  access_gap_a: assert property ($rose(transfer_ack_n) |-> data_strobe_n [*4])
    else $error("next access too soon");
  cover property ($rose(transfer_ack_n_oe) && !read_not_write);
  cover property ($rose(host_data_d2h_oe));
  cover property ($rose(transfer_ack_n) ##[4:8] $fell(data_strobe_n));
endmodule
`default_nettype wire

// >>> verif/ahp_tb.sv
// Self-checking bench joining the device end and the host end through the interface.
// Assumes both ends share one 125 MHz clock and an active-high reset.
`timescale 1ns/1ns
`default_nettype none
module ahp_tb;
  import ahp_pkg::*;
  logic              clk_in, rst_in, req, req_rd, busy, done, lsel, bsel;
  logic              user_wr, user_rd, in_rst;
  logic              ack_seen = 1'b0;
  logic [ADDR_W-1:0] req_addr, uaddr, wr_addr;
  logic [DATA_W-1:0] req_wdata, rdata, uwdata, wr_data, acnt, rd_model;
  logic [CHAN_W-1:0] lso, lsoe, bso, bsoe;
  logic [BUFC_W-1:0] lreq, breq, lbe, bbe;
  int                err_total, total_checks;
  int                wr_seen = 0;
  int                rd_seen = 0;
  ahp_if bus ();
  // Device memory stand-in: read data is a fixed function of the address
  assign rd_model = {1'b0, uaddr} ^ 16'h5A5A;
  ahp_device ahp_device_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus.device),
    .local_idle_level_select_in(lsel), .backplane_idle_level_select_in(bsel),
    .local_serial_data_in(32'h0000_0000), .backplane_serial_data_in(32'h0000_0000),
    .local_buffer_request_in(lreq), .backplane_buffer_request_in(breq),
    .user_read_data_in(rd_model), .user_write_out(user_wr), .user_read_out(user_rd),
    .user_address_out(uaddr), .user_write_data_out(uwdata), .in_reset_out(in_rst),
    .access_count_out(acnt), .local_serial_out(lso), .local_serial_oe_out(lsoe),
    .backplane_serial_out(bso), .backplane_serial_oe_out(bsoe),
    .local_buffer_enable_out(lbe), .backplane_buffer_enable_out(bbe));
  ahp_host ahp_host_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus.host), .req_in(req),
    .req_read_in(req_rd), .req_address_in(req_addr), .req_write_data_in(req_wdata),
    .busy_out(busy), .done_out(done), .read_data_out(rdata));
  ahp_props ahp_props_inst (.clk_in(clk_in), .rst_in(rst_in), .select_n(bus.select_n),
    .data_strobe_n(bus.data_strobe_n), .read_not_write(bus.read_not_write),
    .host_data_h2d_oe(bus.host_data_h2d_oe), .host_data_d2h_oe(bus.host_data_d2h_oe),
    .transfer_ack_n_oe(bus.transfer_ack_n_oe), .transfer_ack_n(bus.transfer_ack_n));
  // ==========================================================================
  // Clock and monitors
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (bus.transfer_ack_n === 1'b0) ack_seen = 1'b1;
    if (user_wr === 1'b1) begin
      wr_addr = uaddr;
      wr_data = uwdata;
      wr_seen++;
    end
    if (user_rd === 1'b1) rd_seen++;
  end
  // ==========================================================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host end ignores a request while busy, so wait for idle before raising it
  task automatic launch(input logic rd, input logic [14:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    while (busy !== 1'b0 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 50) begin
      err_total++;
      $display("mismatch at %0t: host end stayed busy", $time);
      results();
    end
    req = 1'b1;
    req_rd = rd;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_in);
    req = 1'b0;
  endtask
  // One host access; the host end itself keeps the gap after each one
  task automatic op(input logic rd, input logic [14:0] a, input logic [15:0] d);
    int n;
    launch(rd, a, d);
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 50) begin
      err_total++;
      $display("mismatch at %0t: access never completed", $time);
      results();
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    rst_in = 1'b1;
    req = 1'b0;
    req_rd = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    lsel = 1'b1;
    bsel = 1'b0;
    lreq = 4'hF;
    breq = 4'hA;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(negedge clk_in);
    chk(lbe, 4'h0);
    chk(bbe, 4'h0);
    chk(lso & bso, 32'hFFFF_FFFF);
    chk(lsoe, 32'hFFFF_FFFF);
    chk(bsoe, 32'h0000_0000);
    chk(acnt, 16'h0000);
    chk(bus.transfer_ack_n, 1'b1);
    rst_in = 1'b0;
    @(posedge clk_in);
    #1 chk(in_rst, 1'b1);
    repeat (5) @(negedge clk_in);
    chk(in_rst, 1'b0);
    chk({lbe, bbe}, {lreq, breq});
    chk(lso | bso, 32'h0000_0000);
    chk(lsoe & bsoe, 32'hFFFF_FFFF);
    op(1'b0, 15'h7FFF, 16'hA55A);
    chk(wr_addr, 15'h7FFF);
    chk(wr_data, 16'hA55A);
    chk(ack_seen, 1'b1);
    op(1'b0, 15'h0001, 16'h8001);
    chk({wr_addr, wr_data}, {15'h0001, 16'h8001});
    op(1'b1, 15'h4000, 16'h0000);
    chk(rdata, 16'h1A5A);
    op(1'b1, 15'h0000, 16'hFFFF);
    chk(rdata, 16'h5A5A);
    chk(wr_seen, 2);
    chk(rd_seen, 2);
    chk(acnt, 16'h0004);
    // Reset lands while a write is being acknowledged, between clock edges
    launch(1'b0, 15'h1234, 16'hBEEF);
    repeat (3) @(negedge clk_in);
    chk(bus.transfer_ack_n, 1'b0);
    #2 rst_in = 1'b1;
    #1 chk({lbe, bbe}, 8'h00);
    repeat (3) @(negedge clk_in);
    chk(bus.transfer_ack_n, 1'b1);
    chk(acnt, 16'h0000);
    rst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    op(1'b1, 15'h2AAA, 16'h0000);
    chk(rdata, 16'h70F0);
    chk(acnt, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
